// File: pkg/sicu_pkg.sv
package sicu_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int SICU_AW    = 16;   // word address width
  localparam int SICU_DW    = 16;   // data word width
  localparam int SICU_IXW   = 13;   // character index width
  localparam int SICU_WORDS = 8192; // words of data memory in the sequencer

  // ==========================================================================
  // String limits and fixed values
  // ==========================================================================
  localparam logic [12:0] SICU_MAX_CHARS  = 13'h0FFF;  // longest legal string
  localparam logic [15:0] SICU_POS_MAX    = 16'h0FFF;  // highest insert position
  localparam logic [7:0]  SICU_NUL        = 8'h00;     // terminator and pad byte
  localparam logic [15:0] SICU_EMPTY_WORD = 16'h0000;  // empty result word

  // ==========================================================================
  // Function codes
  // ==========================================================================
  localparam logic [9:0] SICU_FC_INS = 10'h291;  // string_insert_op
  localparam logic [9:0] SICU_FC_EQ  = 10'h29E;
  localparam logic [9:0] SICU_FC_NE  = 10'h29F;
  localparam logic [9:0] SICU_FC_LT  = 10'h2A0;
  localparam logic [9:0] SICU_FC_LE  = 10'h2A1;
  localparam logic [9:0] SICU_FC_GT  = 10'h2A2;
  localparam logic [9:0] SICU_FC_GE  = 10'h2A3;

  // ==========================================================================
  // Result flag positions
  // ==========================================================================
  localparam int SICU_FLG_GT = 0;
  localparam int SICU_FLG_GE = 1;
  localparam int SICU_FLG_EQ = 2;
  localparam int SICU_FLG_NE = 3;
  localparam int SICU_FLG_LT = 4;
  localparam int SICU_FLG_LE = 5;

  // ==========================================================================
  // Types
  // ==========================================================================
  // Condition chain forms; chain_start_form opens a new condition
  typedef enum logic [1:0] {
    SICU_FORM_LOAD = 2'h0,
    SICU_FORM_AND  = 2'h1,
    SICU_FORM_OR   = 2'h2
  } sicu_form_t;

  // Unit states, Gray coded along idle-scan-scan-run-done
  typedef enum logic [2:0] {
    SICU_IDLE  = 3'h0,
    SICU_SCAN1 = 3'h1,
    SICU_SCAN2 = 3'h3,
    SICU_RUN   = 3'h2,
    SICU_DONE  = 3'h6
  } sicu_state_t;

endpackage

// File: pkg/sicu_if.sv
interface sicu_if #(parameter int AW = 16);

  // Command from the sequencer
  logic          cmd_valid;
  logic          cmd_ready;
  logic [9:0]    cmd_code;
  logic [1:0]    cmd_form;
  logic          chain_in;
  logic [AW-1:0] base_string_ptr;
  logic [AW-1:0] second_string_ptr;
  logic [AW-1:0] dest_ptr;
  logic [15:0]   insert_position;
  // Data memory access by the unit
  logic          mem_req;
  logic          mem_we;
  logic [AW-1:0] mem_addr;
  logic [15:0]   mem_wdata;
  logic          mem_ack;
  logic [15:0]   mem_rdata;
  // Result
  logic          res_done;
  logic          fault_indicator;
  logic [5:0]    res_flags;
  logic          chain_out;

  modport dev (
    input  cmd_valid, cmd_code, cmd_form, chain_in, base_string_ptr,
    input  second_string_ptr, dest_ptr, insert_position, mem_ack, mem_rdata,
    output cmd_ready, mem_req, mem_we, mem_addr, mem_wdata,
    output res_done, fault_indicator, res_flags, chain_out
  );

  modport host (
    output cmd_valid, cmd_code, cmd_form, chain_in, base_string_ptr,
    output second_string_ptr, dest_ptr, insert_position, mem_ack, mem_rdata,
    input  cmd_ready, mem_req, mem_we, mem_addr, mem_wdata,
    input  res_done, fault_indicator, res_flags, chain_out
  );

endinterface

// File: verilog/sicu_wmem.sv
module sicu_wmem #(
  parameter int AW    = 16,
  parameter int DW    = 16,
  parameter int WORDS = 8192
) (
  // Clock
  input  wire logic          clk,
  // Single port
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);

  localparam int IW = $clog2(WORDS);

  // ==========================================================================
  // Parameter check
  // ==========================================================================
  if (WORDS != (1 << IW) || IW > AW) begin : g_bad
    $error("sicu_wmem: WORDS must be a power of two within the address width");
  end

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [DW-1:0] mem_r [WORDS];

  // Read-first; high address bits beyond the array wrap
  always_ff @(posedge clk) begin
    if (we) begin
      mem_r[addr[IW-1:0]] <= wdata;
    end
    rdata <= mem_r[addr[IW-1:0]];
  end

endmodule

// File: verilog/sicu_dev.sv
// Functional notes
// - Insert places second string after position, NUL-terminated
// - Result capped at 4095 chars plus NUL
// - One empty input copies the other unchanged
// - Both empty writes word 0000 hex
// - Insert fault on unterminated input or position
// - Insert equals flag when first word 0000
// - Program supplies position 0 to 4095
// - Program keeps destination off inserted string
// - Compare from first character, ON when relation true
// - Codes 670..675 decode six relations, three forms
// - First unequal byte pair decides ordering
// - Equal only when all bytes match including NUL
// - Shorter string padded with 00 hex bytes
// - Compare fault when operand exceeds 4095 chars
// - Six relation flags follow compare result exactly
// - Program never starts a rung with AND form
// - Program follows every compare with output instruction
// - Over-length compare passes OFF condition onward
module sicu_dev
  import sicu_pkg::*;
#(
  parameter int AW = SICU_AW
) (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RESET,
  // Link to the sequencer
  sicu_if.dev       LNK,
  // User-side status
  output logic      BUSY
);

  // ==========================================================================
  // Parameter check
  // ==========================================================================
  if (AW < 12) begin : g_bad
    $error("sicu_dev: address width must cover 2048 words of a string");
  end

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    sicu_state_t   st;
    logic          busy;
    logic          pend;    // memory access outstanding
    logic          side;    // compare: 0 fetching first, 1 fetching second
    logic          wr;      // insert: result word pending write
    logic          lane;    // byte lane of the outstanding read
    logic          first;   // no result word written yet
    logic [12:0]   idx;
    logic [12:0]   len1;
    logic [12:0]   len2;
    logic [12:0]   pos;
    logic [7:0]    hi;
    logic [7:0]    abyte;
    logic [9:0]    code;
    logic [1:0]    form;
    logic          chain;
    logic [AW-1:0] pa;
    logic [AW-1:0] pb;
    logic [AW-1:0] pd;
    logic          gt;
    logic          lt;
    logic          ieq;
    logic          fault;
    logic          ready;
    logic          req;
    logic          we;
    logic [AW-1:0] addr;
    logic [15:0]   wdata;
    logic          done;
    logic          fault_o;
    logic [5:0]    flags;
    logic          chain_o;
  } sicu_dev_state_t;

  sicu_dev_state_t r;
  sicu_dev_state_t n;

  // Working terms
  logic [7:0]  rd_byte;
  logic [13:0] sum;
  logic [12:0] tot;
  logic [12:0] cut;
  logic        src_b;
  logic [12:0] src_i;
  logic        put;
  logic [7:0]  put_b;
  logic        is_ins;
  logic        is_cmp;
  logic        res;

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    n       = r;
    n.req   = 1'b0;
    n.we    = 1'b0;
    n.done  = 1'b0;
    rd_byte = r.lane ? LNK.mem_rdata[7:0] : LNK.mem_rdata[15:8];
    is_ins  = (LNK.cmd_code == SICU_FC_INS);
    is_cmp  = (LNK.cmd_code >= SICU_FC_EQ) && (LNK.cmd_code <= SICU_FC_GE);
    put     = 1'b0;
    put_b   = SICU_NUL;
    res     = 1'b0;

    // Result length, truncated to the longest legal string
    sum = {1'b0, r.len1} + {1'b0, r.len2};
    tot = (sum > {1'b0, SICU_MAX_CHARS}) ? SICU_MAX_CHARS : sum[12:0];
    // A position past the base end appends after it
    cut = (r.pos < r.len1) ? r.pos : r.len1;

    // Source of result character idx: base head, inserted, base tail
    src_b = 1'b0;
    src_i = r.idx;
    if (r.idx < cut) begin
      src_i = r.idx;
    end else if (r.idx < cut + r.len2) begin
      src_b = 1'b1;
      src_i = r.idx - cut;
    end else begin
      src_i = r.idx - r.len2;
    end

    case (r.st)
      SICU_IDLE: begin
        n.ready = 1'b1;
        if (LNK.cmd_valid && r.ready) begin
          n.ready = 1'b0;
          n.code  = LNK.cmd_code;
          n.form  = LNK.cmd_form;
          n.chain = LNK.chain_in;
          n.pa    = LNK.base_string_ptr;
          n.pb    = LNK.second_string_ptr;
          n.pd    = LNK.dest_ptr;
          n.pos   = LNK.insert_position[12:0];
          n.idx   = '0;
          n.pend  = 1'b0;
          n.side  = 1'b0;
          n.wr    = 1'b0;
          n.first = 1'b1;
          n.gt    = 1'b0;
          n.lt    = 1'b0;
          n.ieq   = 1'b0;
          n.fault = 1'b0;
          n.st    = SICU_SCAN1;
          if (!is_ins && !is_cmp) begin
            n.fault = 1'b1;  // unknown code: fault, no memory touched
            n.st    = SICU_DONE;
          end else if (is_ins && LNK.insert_position > SICU_POS_MAX) begin
            n.fault = 1'b1;
            n.st    = SICU_DONE;
          end
        end
      end

      // Both operands are measured first so an over-length one is caught
      // even when an earlier byte would already decide the ordering
      SICU_SCAN1, SICU_SCAN2: begin
        if (!r.pend) begin
          n.pend = 1'b1;
          n.req  = 1'b1;
          n.addr = ((r.st == SICU_SCAN1) ? r.pa : r.pb) + AW'(r.idx[12:1]);
          n.lane = r.idx[0];
        end else if (LNK.mem_ack) begin
          n.pend = 1'b0;
          if (rd_byte == SICU_NUL) begin
            n.idx = '0;
            if (r.st == SICU_SCAN1) begin
              n.len1 = r.idx;
              n.st   = SICU_SCAN2;
            end else begin
              n.len2 = r.idx;
              n.st   = SICU_RUN;
            end
          end else if (r.idx == SICU_MAX_CHARS) begin
            n.fault = 1'b1;
            n.st    = SICU_DONE;
          end else begin
            n.idx = r.idx + 13'h001;
          end
        end
      end

      SICU_RUN: begin
        if (r.code == SICU_FC_INS) begin
          if (r.wr) begin
            if (!r.pend) begin
              n.pend = 1'b1;
              n.req  = 1'b1;
              n.we   = 1'b1;
              n.addr = r.pd + AW'(r.idx[12:1]);
            end else if (LNK.mem_ack) begin
              n.pend  = 1'b0;
              n.wr    = 1'b0;
              n.first = 1'b0;
              if (r.first) begin
                n.ieq = (r.wdata == SICU_EMPTY_WORD);
              end
              if (r.idx == tot) begin
                n.st = SICU_DONE;
              end else begin
                n.idx = r.idx + 13'h001;
              end
            end
          end else if (r.idx == tot) begin
            put   = 1'b1;  // terminator after the last character
            put_b = SICU_NUL;
          end else if (!r.pend) begin
            n.pend = 1'b1;
            n.req  = 1'b1;
            n.addr = (src_b ? r.pb : r.pa) + AW'(src_i[12:1]);
            n.lane = src_i[0];
          end else if (LNK.mem_ack) begin
            n.pend = 1'b0;
            put    = 1'b1;
            put_b  = rd_byte;
          end
        end else begin
          // Byte-serial compare; fetch first then second operand byte
          if (!r.pend) begin
            n.pend = 1'b1;
            n.req  = 1'b1;
            n.addr = (r.side ? r.pb : r.pa) + AW'(r.idx[12:1]);
            n.lane = r.idx[0];
          end else if (LNK.mem_ack) begin
            n.pend = 1'b0;
            if (!r.side) begin
              n.abyte = rd_byte;
              n.side  = 1'b1;
            end else begin
              n.side = 1'b0;
              if (r.abyte != rd_byte) begin
                // A NUL against a character is the 00 padding case
                n.gt = (r.abyte > rd_byte);
                n.lt = (r.abyte < rd_byte);
                n.st = SICU_DONE;
              end else if (rd_byte == SICU_NUL) begin
                n.st = SICU_DONE;
              end else begin
                n.idx = r.idx + 13'h001;
              end
            end
          end
        end
      end

      SICU_DONE: begin
        n.done    = 1'b1;
        n.ready   = 1'b1;
        n.st      = SICU_IDLE;
        n.fault_o = r.fault;
        if (r.code == SICU_FC_INS) begin
          // Insert touches only the equals flag; condition passes through
          n.flags[SICU_FLG_EQ] = r.ieq && !r.fault;
          n.chain_o            = r.chain;
        end else begin
          n.flags[SICU_FLG_GT] = !r.fault && r.gt;
          n.flags[SICU_FLG_GE] = !r.fault && !r.lt;
          n.flags[SICU_FLG_EQ] = !r.fault && !r.gt && !r.lt;
          n.flags[SICU_FLG_NE] = !r.fault && (r.gt || r.lt);
          n.flags[SICU_FLG_LT] = !r.fault && r.lt;
          n.flags[SICU_FLG_LE] = !r.fault && !r.gt;
          case (r.code)
            SICU_FC_EQ: res = !r.gt && !r.lt;
            SICU_FC_NE: res = r.gt || r.lt;
            SICU_FC_LT: res = r.lt;
            SICU_FC_LE: res = !r.gt;
            SICU_FC_GT: res = r.gt;
            SICU_FC_GE: res = !r.lt;
            default:    res = 1'b0;
          endcase
          if (r.fault) begin
            n.chain_o = 1'b0;
          end else if (r.form == SICU_FORM_AND) begin
            n.chain_o = r.chain && res;
          end else if (r.form == SICU_FORM_OR) begin
            n.chain_o = r.chain || res;
          end else begin
            n.chain_o = res;
          end
        end
      end

      default: begin
        n.st = SICU_IDLE;
      end
    endcase

    // Pack result bytes high lane first; an even-slot NUL pads with 00
    if (put) begin
      if (!r.idx[0]) begin
        n.hi = put_b;
        if (put_b == SICU_NUL) begin
          n.wdata = {SICU_NUL, SICU_NUL};
          n.wr    = 1'b1;
        end else begin
          n.idx = r.idx + 13'h001;
        end
      end else begin
        n.wdata = {r.hi, put_b};
        n.wr    = 1'b1;
      end
    end

    n.busy = (n.st != SICU_IDLE);
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge CLK) begin
    if (RESET) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign LNK.cmd_ready       = r.ready;
  assign LNK.mem_req         = r.req;
  assign LNK.mem_we          = r.we;
  assign LNK.mem_addr        = r.addr;
  assign LNK.mem_wdata       = r.wdata;
  assign LNK.res_done        = r.done;
  assign LNK.fault_indicator = r.fault_o;
  assign LNK.res_flags       = r.flags;
  assign LNK.chain_out       = r.chain_o;
  assign BUSY                = r.busy;

endmodule

// File: verilog/sicu_host.sv
module sicu_host
  import sicu_pkg::*;
#(
  parameter int AW    = SICU_AW,
  parameter int WORDS = SICU_WORDS
) (
  // Clock and reset
  input  wire logic          CLK,
  input  wire logic          RESET,
  // Link to the unit
  sicu_if.host               LNK,
  // Instruction request
  input  wire logic          START,
  input  wire logic [9:0]    OP_CODE,
  input  wire logic [1:0]    CHAIN_FORM,
  input  wire logic          RUNG_START,
  input  wire logic          CHAIN_IN,
  input  wire logic [AW-1:0] PTR_BASE,
  input  wire logic [AW-1:0] PTR_SECOND,
  input  wire logic [AW-1:0] PTR_DEST,
  input  wire logic [15:0]   POSITION,
  // Instruction answer
  output logic               DONE,
  output logic               REFUSED,
  output logic               FAULT,
  output logic [5:0]         FLAGS,
  output logic               CHAIN_OUT,
  output logic               BUSY,
  // Data memory access while idle
  input  wire logic          MEM_WE,
  input  wire logic [AW-1:0] MEM_ADDR,
  input  wire logic [15:0]   MEM_WDATA,
  output logic [15:0]        MEM_RDATA
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic          valid;
    logic [9:0]    code;
    logic [1:0]    form;
    logic          chain;
    logic [AW-1:0] pa;
    logic [AW-1:0] pb;
    logic [AW-1:0] pd;
    logic [15:0]   pos;
    logic          ack;
    logic          busy;
    logic          done;
    logic          refused;
    logic          fault;
    logic [5:0]    flags;
    logic          chain_o;
  } sicu_host_state_t;

  sicu_host_state_t r;
  sicu_host_state_t n;

  logic          m_we;
  logic [AW-1:0] m_addr;
  logic [15:0]   m_wdata;

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    n         = r;
    n.done    = 1'b0;
    n.refused = 1'b0;
    n.ack     = LNK.mem_req;  // memory answers one cycle after each request
    if (r.valid && LNK.cmd_ready) begin
      n.valid = 1'b0;
    end
    if (START && !r.busy) begin
      if (CHAIN_FORM == SICU_FORM_AND && RUNG_START) begin
        n.refused = 1'b1;
      end else begin
        n.valid = 1'b1;
        n.busy  = 1'b1;
        n.code  = OP_CODE;
        n.form  = CHAIN_FORM;
        n.chain = CHAIN_IN;
        n.pa    = PTR_BASE;
        n.pb    = PTR_SECOND;
        n.pd    = PTR_DEST;
        n.pos   = POSITION;
      end
    end
    if (LNK.res_done) begin
      n.busy    = 1'b0;
      n.done    = 1'b1;
      n.fault   = LNK.fault_indicator;
      n.flags   = LNK.res_flags;
      n.chain_o = LNK.chain_out;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ==========================================================================
  // Data memory, unit first; user writes only land while idle
  // ==========================================================================
  always_comb begin
    m_we    = LNK.mem_req ? LNK.mem_we : (MEM_WE && !r.busy);
    m_addr  = LNK.mem_req ? LNK.mem_addr : MEM_ADDR;
    m_wdata = LNK.mem_req ? LNK.mem_wdata : MEM_WDATA;
  end

  sicu_wmem #(
    .AW    (AW),
    .DW    (SICU_DW),
    .WORDS (WORDS)
  ) u_wmem (
    .clk   (CLK),
    .we    (m_we),
    .addr  (m_addr),
    .wdata (m_wdata),
    .rdata (MEM_RDATA)
  );

  // Link and user outputs from registers
  assign LNK.cmd_valid         = r.valid;
  assign LNK.cmd_code          = r.code;
  assign LNK.cmd_form          = r.form;
  assign LNK.chain_in          = r.chain;
  assign LNK.base_string_ptr   = r.pa;
  assign LNK.second_string_ptr = r.pb;
  assign LNK.dest_ptr          = r.pd;
  assign LNK.insert_position   = r.pos;
  assign LNK.mem_ack           = r.ack;
  assign LNK.mem_rdata         = MEM_RDATA;
  assign DONE                  = r.done;
  assign REFUSED               = r.refused;
  assign FAULT                 = r.fault;
  assign FLAGS                 = r.flags;
  assign CHAIN_OUT             = r.chain_o;
  assign BUSY                  = r.busy;

endmodule

// File: verification/sicu_chk_sva.sv
module sicu_chk_sva
  import sicu_pkg::*;
(
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RESET,
  // Command link
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [9:0]  cmd_code,
  input wire logic [1:0]  cmd_form,
  input wire logic        chain_in,
  input wire logic [15:0] insert_position,
  // Memory link
  input wire logic        mem_req,
  input wire logic        mem_ack,
  // Result
  input wire logic        res_done,
  input wire logic        fault_indicator,
  input wire logic [5:0]  res_flags,
  input wire logic        chain_out
);
  // ====================
  // Helper state
  // ====================
  logic [9:0] code_r;
  logic [1:0] form_r;
  logic       chin_r;
  logic       cmp;
  logic       rel;
  logic       exp_chain;

  // Command kept from accept, since inputs may move on before the answer
  always_ff @(posedge CLK) begin
    if (cmd_valid && cmd_ready) begin
      code_r <= cmd_code;
      form_r <= cmd_form;
      chin_r <= chain_in;
    end
  end

  // Expected condition; flag index is code offset plus two, modulo six
  always_comb begin
    cmp = (code_r >= SICU_FC_EQ) && (code_r <= SICU_FC_GE);
    rel = cmp ? res_flags[(int'(code_r - SICU_FC_EQ) + 2) % 6] : 1'b0;
    exp_chain = (form_r == SICU_FORM_AND) ? (rel & chin_r) : (form_r == SICU_FORM_OR) ? (rel | chin_r) : rel;
  end

  // ====================
  // Assertions
  // ====================
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  chk_ack_next: assert property (mem_req |=> mem_ack) else $error("memory ack missing");
  chk_req_gap: assert property (mem_req |=> !mem_req) else $error("request before ack");
  chk_take_drop: assert property (cmd_valid && cmd_ready |=> !cmd_ready) else $error("ready held after accept");
  chk_done_ready: assert property (res_done |-> cmd_ready) else $error("not ready at done");
  chk_flag_set: assert property (res_done && cmp && !fault_indicator |->
    $onehot({res_flags[0], res_flags[2], res_flags[4]}) && res_flags[3] == !res_flags[2] &&
    res_flags[1] == (res_flags[0] | res_flags[2]) && res_flags[5] == (res_flags[4] | res_flags[2]))
    else $error("relation flags inconsistent");
  chk_fault_off: assert property (res_done && cmp && fault_indicator |->
    res_flags == 6'h00 && !chain_out) else $error("fault without off condition");
  chk_chain_calc: assert property (res_done && cmp && !fault_indicator |->
    chain_out == exp_chain) else $error("chain result wrong");
  chk_pos_fault: assert property (cmd_valid && cmd_ready && cmd_code == SICU_FC_INS &&
    insert_position > SICU_POS_MAX |-> ##[1:4] (res_done && fault_indicator)) else $error("position fault missing");
endmodule

// File: verification/test_string_insert_compare_unit.sv
module test_string_insert_compare_unit;
  import sicu_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Signals and parts
  // ====================
  typedef struct { string a; string b; logic [5:0] f; } sicu_row_t;
  logic        clk = 0, rst = 1, start = 0, rung = 0, chin = 0, we = 0;
  logic [9:0]  code = 0;
  logic [1:0]  form = 0;
  logic [15:0] pa = 16'h1800, pb = 16'h1810, pd = 16'h1820, pos = 0, addr = 0, wd = 0, rd;
  logic [5:0]  flags;
  logic        done, refused, fault, chout, hbusy, dbusy, r, e, ci, sr, sd;
  int          err_count = 0, check_count = 0;
  // Flags: less 38, greater 0B, equal 26
  sicu_row_t rows[4] = '{'{"AD", "BC", 6'h38}, '{"ABC", "AB", 6'h0B}, '{"AB", "AB", 6'h26}, '{"ADC", "B", 6'h38}};

  always #20 clk = ~clk;
  sicu_if lk ();
  sicu_dev sicu_dev_inst (.CLK(clk), .RESET(rst), .LNK(lk.dev), .BUSY(dbusy));
  sicu_host sicu_host_inst (.CLK(clk), .RESET(rst), .LNK(lk.host), .START(start), .OP_CODE(code),
    .CHAIN_FORM(form), .RUNG_START(rung), .CHAIN_IN(chin), .PTR_BASE(pa), .PTR_SECOND(pb), .PTR_DEST(pd),
    .POSITION(pos), .DONE(done), .REFUSED(refused), .FAULT(fault), .FLAGS(flags), .CHAIN_OUT(chout),
    .BUSY(hbusy), .MEM_WE(we), .MEM_ADDR(addr), .MEM_WDATA(wd), .MEM_RDATA(rd));
  sicu_chk_sva sicu_chk_sva_inst (.CLK(clk), .RESET(rst), .cmd_valid(lk.cmd_valid), .cmd_ready(lk.cmd_ready),
    .cmd_code(lk.cmd_code), .cmd_form(lk.cmd_form), .chain_in(lk.chain_in), .insert_position(lk.insert_position),
    .mem_req(lk.mem_req), .mem_ack(lk.mem_ack), .res_done(lk.res_done), .fault_indicator(lk.fault_indicator),
    .res_flags(lk.res_flags), .chain_out(lk.chain_out));

  // ====================
  // Tasks
  // ====================
  task tick(); @(posedge clk); #1; endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    tick(); we = 1; addr = a; wd = d;
    tick(); we = 0;
  endtask
  // High byte first; reading past the end of a string yields the NUL
  task put(input logic [15:0] a, input string s);
    for (int i = 0; i <= s.len() / 2; i++) wr(a + 16'(i), {s[2*i], s[2*i+1]});
  endtask
  task rd_chk(input logic [15:0] a, input logic [15:0] exp);
    tick(); addr = a;
    tick(); chk(rd, exp);
  endtask
  task run(input logic [9:0] c, input logic [1:0] f, input logic i, input logic [15:0] p);
    int n;
    tick(); code = c; form = f; chin = i; pos = p; start = 1;
    tick(); start = 0;
    chk(16'(hbusy), 16'h0001);
    for (n = 0; done !== 1'b1 && n < 40000; n++) tick();
    if (n >= 40000) chk(16'h0000, 16'h0001);
    chk(16'({hbusy, dbusy}), 16'h0000);
  endtask
  task note(input string s); $display("%s finished, %0d checks", s, check_count); endtask
  task end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ====================
  // Sequence
  // ====================
  // Longest insert stays near 30k cycles, so this leaves ample margin
  initial begin
    #(90000 * 40);
    err_count++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge clk);
    #1 chk(16'({lk.cmd_ready, hbusy, dbusy}), 16'h0000);
    rst = 0;
    tick(); chk(16'(lk.cmd_ready), 16'h0001);
    note("reset");
    foreach (rows[i]) begin
      put(pa, rows[i].a);
      put(pb, rows[i].b);
      for (int k = 0; k < 6; k++) begin
        ci = 1'(k % 2);
        run(10'(SICU_FC_EQ + k), 2'(k % 3), ci, 16'h0000);
        r = rows[i].f[(k + 2) % 6];
        e = (k % 3 == 1) ? (r & ci) : (k % 3 == 2) ? (r | ci) : r;
        chk(16'(flags), 16'(rows[i].f));
        chk(16'(chout), 16'(e));
        chk(16'(fault), 16'h0000);
      end
    end
    note("compare table");
    rst = 1;
    tick(); chk(16'({lk.cmd_ready, fault, flags}), 16'h0000);
    rst = 0;
    tick(); chk(16'(lk.cmd_ready), 16'h0001);
    note("second reset");
    put(pa, "ABC");
    put(pb, "XY");
    run(SICU_FC_INS, 2'h0, 1'b1, 16'h0001);
    chk(16'({fault, flags[2]}), 16'h0000);
    rd_chk(16'h1820, 16'h4158);
    rd_chk(16'h1821, 16'h5942);
    rd_chk(16'h1822, 16'h4300);
    put(pa, "");
    run(SICU_FC_INS, 2'h0, 1'b0, 16'h0000);
    rd_chk(16'h1820, 16'h5859);
    rd_chk(16'h1821, 16'h0000);
    put(pb, "");
    run(SICU_FC_INS, 2'h0, 1'b0, 16'h0000);
    rd_chk(16'h1820, SICU_EMPTY_WORD);
    chk(16'(flags[2]), 16'h0001);
    run(SICU_FC_INS, 2'h0, 1'b0, 16'h1000);
    chk(16'({fault, flags[2]}), 16'h0002);
    note("insert");
    tick(); code = SICU_FC_EQ; form = SICU_FORM_AND; rung = 1; start = 1;
    tick(); start = 0;
    sr = refused;
    sd = done;
    for (int n = 0; n < 4; n++) begin
      tick(); sr = sr | refused; sd = sd | done;
    end
    rung = 0;
    chk(16'({sr, sd}), 16'h0002);
    run(10'h000, 2'h0, 1'b1, 16'h0000);
    chk(16'({fault, chout, flags}), 16'h0080);
    note("refusal");
    for (int i = 0; i < 2048; i++) wr(16'h1000 + 16'(i), 16'h4141);
    pa = 16'h1000;
    put(pb, "XY");
    run(SICU_FC_GT, SICU_FORM_OR, 1'b1, 16'h0000);
    chk(16'({fault, chout, flags}), 16'h0080);
    run(SICU_FC_INS, 2'h0, 1'b0, 16'h0000);
    chk(16'(fault), 16'h0001);
    wr(16'h17FF, 16'h4100);
    pd = 16'h0000;
    run(SICU_FC_INS, 2'h0, 1'b0, 16'h0FFE);
    chk(16'(fault), 16'h0000);
    rd_chk(16'h07FE, 16'h4141);
    rd_chk(16'h07FF, 16'h5800);
    note("length limits");
    end_sim();
  end
endmodule
